// ---- common/adc_mode_pkg.sv ----
/*
 * Constants for the converter mode-control block: register offsets,
 * field positions, reset values, mode codes, timing and engine states.
 * Assumes a 40 MHz encode clock drives the core logic.
 */
package adc_mode_pkg;
	// ==========================================================
	// Geometry
	localparam int CHANNELS  = 4;      // Converter channels
	localparam int SAMPLE_W  = 14;     // Bits per sample
	localparam int WORD_BITS = 16;     // Serial word length
	localparam int ADDR_W    = 7;      // Address field width
	localparam int DATA_W    = 8;      // Register width

	// ==========================================================
	// Register offsets
	localparam logic [6:0] OFF_RESET   = 7'h00;
	localparam logic [6:0] OFF_FORMAT  = 7'h01;
	localparam logic [6:0] OFF_OUTPUT  = 7'h02;
	localparam logic [6:0] OFF_PAT_MSB = 7'h03;
	localparam logic [6:0] OFF_PAT_LSB = 7'h04;
	localparam logic [7:0] REG_RESET   = 8'h00;  // All registers

	// ==========================================================
	// Field positions
	localparam int RW_BIT       = 15;  // Read flag in serial word
	localparam int SOFT_RST_BIT = 7;   // Reset register
	localparam int DUTY_OFF_BIT = 7;   // Format register
	localparam int RANDOMIZER_ENABLE_BIT     = 6;
	localparam int SIGNED_BIT   = 5;
	localparam int SLEEP_BIT    = 4;
	localparam int DRIVE_LSB    = 5;   // Output mode register
	localparam int TERM_BIT     = 4;
	localparam int OUT_OFF_BIT  = 3;
	localparam int TEST_EN_BIT  = 7;   // Pattern high register

	// ==========================================================
	// Mode codes
	localparam logic [2:0] LANE_2_16   = 3'h0;
	localparam logic [2:0] LANE_1_14   = 3'h5;
	localparam logic [2:0] DRIVE_3MA5  = 3'h0;
	localparam logic [2:0] DRIVE_1MA75 = 3'h7;

	// ==========================================================
	// Timing
	localparam int CLK_HZ            = 40_000_000;
	localparam int SLEEP_WAKE_MS     = 2;
	localparam int SLEEP_WAKE_CYCLES = SLEEP_WAKE_MS * (CLK_HZ / 1000);
	localparam int NAP_WAKE_CYCLES   = 100;   // Encode clock cycles

	// Serial engine phases
	typedef enum logic [1:0] {ST_IDLE, ST_HEAD, ST_DATA, ST_DONE}
		engine_state_t;
endpackage : adc_mode_pkg

// ---- common/mode_bus_if.sv ----
/*
 * Carrier between the mode-control core, its serial engine and its
 * sample formatter. All signals live on the encode clock.
 */
`timescale 1ns/10ps
interface mode_bus_if;
	logic        frame_done;   // Pulse: full 16-bit word at frame end
	logic [15:0] frame_word;   // Captured serial word
	logic [6:0]  read_addr;    // Address while header completes
	logic [7:0]  read_data;    // Register contents for readback
	logic        randomize;    // Formatter controls
	logic        signed_fmt;
	logic        test_en;
	logic [13:0] pattern;

	modport engine (output frame_done, frame_word, read_addr,
		input read_data);
	modport core (input frame_done, frame_word, read_addr,
		output read_data, randomize, signed_fmt, test_en, pattern);
	modport formatter (input randomize, signed_fmt, test_en, pattern);
endinterface : mode_bus_if

// ---- hdl/serial_port_engine.sv ----
/*
 * Serial configuration engine: shifts the 16-bit word, shifts readback
 * out on the open-drain line. Assumes synchronised pins and edge pulses.
 */
`timescale 1ns/10ps
module serial_port_engine (
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic active_i,     // Serial mode and select low
	input  wire logic sck_rise_i,   // Serial clock rising edge pulse
	input  wire logic sck_fall_i,   // Serial clock falling edge pulse
	input  wire logic sdi_i,        // Synchronised data in
	mode_bus_if.engine bus,
	output logic      sdo_oe_o      // High: pull output line low
);
	// ==========================================================
	// State
	logic [4:0]  bit_count;   // Rising edges taken this frame
	logic [15:0] shift;       // Incoming word
	logic [7:0]  read_shift;  // Outgoing register bits
	logic        reading;     // Read frame, header complete
	logic        active_q;    // Frame seen last cycle

	// Header sits in the low shift bits on the eighth edge
	localparam int WB = adc_mode_pkg::WORD_BITS;
	assign bus.read_addr = {shift[5:0], sdi_i};
	wire take_edge = sck_rise_i && (bit_count < 5'(WB));

	// Shift, count and readback; frame state clears with select high
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bit_count  <= '0;
			shift      <= '0;
			read_shift <= '0;
			reading    <= 1'b0;
		end else if (!active_i) begin
			bit_count <= '0;
			reading   <= 1'b0;
		// [R14] Only first sixteen
		end else if (take_edge) begin
			shift     <= {shift[14:0], sdi_i};
			bit_count <= bit_count + 5'h1;
			// [R17] Load readback data
			if (bit_count == 5'h7 && shift[6]) begin
				read_shift <= bus.read_data;
				reading    <= 1'b1;
			end
		// [R26] Next bit per fall
		end else if (sck_fall_i && reading && bit_count > 5'h8 &&
				bit_count < 5'(WB)) begin
			read_shift <= {read_shift[6:0], 1'b0};
		end
	end

	// Frame closes on select rising; short frames are dropped
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			active_q       <= 1'b0;
			bus.frame_done <= 1'b0;
			bus.frame_word <= '0;
		end else begin
			active_q       <= active_i;
			// [R13] Whole word only
			bus.frame_done <= active_q && !active_i && bit_count == 5'(WB);
			bus.frame_word <= shift;
		end
	end

	// [R18] Drive low only
	// Select high lets go of the line in the same cycle
	assign sdo_oe_o = reading && active_i && !read_shift[7];

	// ==========================================================
	// Checks
	property p_count_cap;
		@(posedge clk_i) disable iff (sys_rst_i)
		(bit_count == 5'(WB)) && sck_rise_i |=> bit_count == 5'(WB) || !active_i;
	endproperty
	a_count_cap: assert property (p_count_cap) // [R14]
		else $error("bit count moved past sixteen");

	property p_sdo_read_only;
		@(posedge clk_i) disable iff (sys_rst_i)
		sdo_oe_o |-> reading && active_i;
	endproperty
	a_sdo_read_only: assert property (p_sdo_read_only) // [R18]
		else $error("output line pulled outside a read");
endmodule : serial_port_engine

// ---- hdl/sample_formatter.sv ----
/*
 * Output formatting per channel: coding, randomizer, pattern override.
 * Assumes samples arrive on the encode clock, one word per channel.
 */
`timescale 1ns/10ps
module sample_formatter #(
	parameter int CHANNELS = adc_mode_pkg::CHANNELS,
	parameter int SAMPLE_W = adc_mode_pkg::SAMPLE_W
) (
	input  wire logic                               clk_i,
	input  wire logic                               sys_rst_i,
	input  wire logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_i,
	mode_bus_if.formatter                           bus,
	output logic      [CHANNELS-1:0][SAMPLE_W-1:0] sample_bits_o
);
	// Carrier holds a fourteen-bit pattern at most
	if (CHANNELS < 1 || SAMPLE_W < 3 || SAMPLE_W > 14) begin : g_bad
		$error("formatter width outside what the carrier holds");
	end

	// ==========================================================
	// Per-channel stages
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		wire [SAMPLE_W-1:0] raw = sample_i[ch];
		// Signed coding flips the top bit of offset binary
		wire [SAMPLE_W-1:0] coded = bus.signed_fmt ?
			{~raw[SAMPLE_W-1], raw[SAMPLE_W-2:0]} : raw;
		// [R01] Randomize upper bits
		wire [SAMPLE_W-1:0] mixed = bus.randomize ?
			{coded[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){coded[0]}}, coded[0]}
			: coded;
		// [R02] [R03] Pattern forced, last
		wire [SAMPLE_W-1:0] chosen = bus.test_en ?
			bus.pattern[SAMPLE_W-1:0] : mixed;

		// Register the word so the serializer sees clean data
		always_ff @(posedge clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				sample_bits_o[ch] <= '0;
			end else begin
				sample_bits_o[ch] <= chosen;
			end
		end
	end

	// ==========================================================
	// Checks
	property p_pattern_wins;
		@(posedge clk_i) disable iff (sys_rst_i)
		bus.test_en |=> sample_bits_o[0] == $past(bus.pattern);
	endproperty
	a_pattern_wins: assert property (p_pattern_wins) // [R03]
		else $error("pattern not output unmodified");

	property p_randomizer_enable_lsb;
		@(posedge clk_i) disable iff (sys_rst_i)
		bus.randomize && !bus.test_en |=>
			sample_bits_o[1][SAMPLE_W-2:0] ==
			($past(sample_i[1][SAMPLE_W-2:0]) ^
			{{(SAMPLE_W-2){$past(sample_i[1][0])}}, 1'b0}) &&
			sample_bits_o[1][SAMPLE_W-1] ==
			($past(sample_i[1][SAMPLE_W-1]) ^ $past(bus.signed_fmt) ^
			$past(sample_i[1][0]));
	endproperty
	a_randomizer_enable_lsb: assert property (p_randomizer_enable_lsb) // [R01]
		else $error("randomizer output wrong");
endmodule : sample_formatter

// ---- hdl/adc_mode_control_port.sv ----
/*
 * Mode-control core of a four-channel converter: pin synchronisers,
 * serial register file or strap decode, power sequencing, output drive.
 * Assumes pins are asynchronous to the 40 MHz encode clock and samples
 * come from the converter core on that clock.
 */
// Function
// [R01] Randomizer XORs LSB into upper bits
// [R02] Test mode forces the pattern everywhere
// [R03] Pattern overrides coding and randomizer
// [R04] Output disable turns off every pair
// [R05] Sleep powers down; two ms wake
// [R06] Nap per channel; 100 cycle wake
// [R07] Host waits 50 us for settling
// [R08] Select high makes pins static straps
// [R09] Strap select picks lane and width
// [R10] Strap clock picks drive current
// [R11] Strap data in picks sleep
// [R12] Strap data out picks termination
// [R13] One sixteen-bit word per write
// [R14] Only first sixteen rising edges count
// [R15] Host sends flag, address, data
// [R16] Write flag zero stores data
// [R17] Read returns data, register untouched
// [R18] Serial output is open drain
// [R19] Reset bit clears registers, briefly sleeps
// [R20] Reset bit self clears, write only
// [R21] Format bits six, five: randomize, signed
// [R22] Low five bits: nap channels, sleep
// [R23] Host sends software reset first
// [R24] Low pattern register gives bits 7..0
// [R25] Duty stabilizer forced on in straps
// [R26] Readback shifts out MSB first
`timescale 1ns/10ps
module adc_mode_control_port #(
	parameter int SLEEP_WAKE_CYCLES = adc_mode_pkg::SLEEP_WAKE_CYCLES,
	parameter int NAP_WAKE_CYCLES   = adc_mode_pkg::NAP_WAKE_CYCLES
) (
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             programming_select_i,
	input  wire logic             chip_select_n_i,
	input  wire logic             serial_clock_i,
	input  wire logic             serial_data_i,
	input  wire logic             serial_out_i,
	input  wire logic [3:0][13:0] sample_i,
	output logic                  serial_out_o,
	output logic                  serial_out_oe_o,
	output logic      [3:0][13:0] sample_bits_o,
	output logic                  data_pair_oe_o,
	output logic                  data_clock_out_oe_o,
	output logic                  frame_marker_oe_o,
	output logic                  sleep_o,
	output logic      [3:0]       channel_nap_o,
	output logic                  converter_ready_o,
	output logic      [3:0]       channel_ready_o,
	output logic      [2:0]       lane_mode_o,
	output logic      [2:0]       drive_current_o,
	output logic                  termination_enable_o,
	output logic                  duty_stabilizer_disable_o
);
	// ==========================================================
	// Parameter checks
	if (SLEEP_WAKE_CYCLES < 1 || NAP_WAKE_CYCLES < 1) begin : g_bad
		$error("wake counts must be at least one cycle");
	end

	localparam int SW = $clog2(SLEEP_WAKE_CYCLES + 1);  // Sleep counter
	localparam int NW = $clog2(NAP_WAKE_CYCLES + 1);    // Nap counter

	// ==========================================================
	// Pin synchronisers
	localparam int PINS = 5;
	wire  [PINS-1:0] pin_raw = {programming_select_i, chip_select_n_i,
		serial_clock_i, serial_data_i, serial_out_i};
	logic [PINS-1:0] pin_meta;   // First stage, read by second only
	logic [PINS-1:0] pin_sync;   // Safe levels
	// Idle levels: select high, line pulled up; no false frame at reset
	localparam logic [PINS-1:0] PIN_IDLE = 5'h09;

	// Two flops per pin; any pin may move at any time
	for (genvar p = 0; p < PINS; p++) begin : g_sync
		always_ff @(posedge clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				pin_meta[p] <= PIN_IDLE[p];
				pin_sync[p] <= PIN_IDLE[p];
			end else begin
				pin_meta[p] <= pin_raw[p];
				pin_sync[p] <= pin_meta[p];
			end
		end
	end

	wire psel_s = pin_sync[4];   // Strap mode when high
	wire csn_s  = pin_sync[3];
	wire sck_s  = pin_sync[2];
	wire sdi_s  = pin_sync[1];
	wire sdo_s  = pin_sync[0];

	// Serial clock edge finder
	logic sck_q;   // Synchronised clock, one cycle late
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sck_q <= 1'b0;
		end else begin
			sck_q <= sck_s;
		end
	end

	// [R08] Straps or serial
	wire serial_mode = !psel_s;
	wire sck_rise    = sck_s && !sck_q;
	wire sck_fall    = !sck_s && sck_q;
	wire active      = serial_mode && !csn_s;

	// ==========================================================
	// Serial engine and formatter
	mode_bus_if bus ();

	serial_port_engine u_engine (
		.clk_i      (clk_i),
		.sys_rst_i  (sys_rst_i),
		.active_i   (active),
		.sck_rise_i (sck_rise),
		.sck_fall_i (sck_fall),
		.sdi_i      (sdi_s),
		.bus        (bus.engine),
		.sdo_oe_o   (serial_out_oe_o)
	);

	sample_formatter u_format (
		.clk_i         (clk_i),
		.sys_rst_i     (sys_rst_i),
		.sample_i      (sample_i),
		.bus           (bus.formatter),
		.sample_bits_o (sample_bits_o)
	);

	// Open drain: the level driven is always low
	assign serial_out_o = 1'b0;

	// ==========================================================
	// Register file
	logic [7:0] format_power;   // Coding and power-down
	logic [7:0] output_mode;    // Drive, termination, lanes
	logic [7:0] pattern_msb;    // Test enable and top bits
	logic [7:0] pattern_lsb;    // Low pattern bits

	wire [6:0] wr_addr = bus.frame_word[14:8];
	wire [7:0] wr_data = bus.frame_word[7:0];
	// [R16] Write on flag zero
	wire wr_hit = bus.frame_done && serial_mode &&
		!bus.frame_word[adc_mode_pkg::RW_BIT];
	// [R19] Reset request
	wire soft_reset = wr_hit && wr_addr == adc_mode_pkg::OFF_RESET &&
		wr_data[adc_mode_pkg::SOFT_RST_BIT];
	wire wr_format  = wr_hit && wr_addr == adc_mode_pkg::OFF_FORMAT;
	wire wr_output  = wr_hit && wr_addr == adc_mode_pkg::OFF_OUTPUT;
	wire wr_pat_msb = wr_hit && wr_addr == adc_mode_pkg::OFF_PAT_MSB;
	wire wr_pat_lsb = wr_hit && wr_addr == adc_mode_pkg::OFF_PAT_LSB;

	// Updates only at frame end; reset bit itself is never stored
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			format_power <= adc_mode_pkg::REG_RESET;
			output_mode  <= adc_mode_pkg::REG_RESET;
			pattern_msb  <= adc_mode_pkg::REG_RESET;
			pattern_lsb  <= adc_mode_pkg::REG_RESET;
		// [R20] Self clearing reset
		end else if (soft_reset) begin
			format_power <= adc_mode_pkg::REG_RESET;
			output_mode  <= adc_mode_pkg::REG_RESET;
			pattern_msb  <= adc_mode_pkg::REG_RESET;
			pattern_lsb  <= adc_mode_pkg::REG_RESET;
		end else begin
			if (wr_format) format_power <= wr_data;
			if (wr_output) output_mode <= wr_data;
			if (wr_pat_msb) pattern_msb <= wr_data;
			if (wr_pat_lsb) pattern_lsb <= wr_data;
		end
	end

	// Readback select; reset register and holes read as zero
	wire [6:0] ra = bus.read_addr;
	// [R17] Readback mux
	assign bus.read_data =
		(ra == adc_mode_pkg::OFF_FORMAT)  ? format_power :
		(ra == adc_mode_pkg::OFF_OUTPUT)  ? output_mode  :
		(ra == adc_mode_pkg::OFF_PAT_MSB) ? pattern_msb  :
		(ra == adc_mode_pkg::OFF_PAT_LSB) ? pattern_lsb  : 8'h00;

	// ==========================================================
	// Effective settings
	// [R21] Coding controls
	assign bus.randomize  = serial_mode && format_power[adc_mode_pkg::RANDOMIZER_ENABLE_BIT];
	assign bus.signed_fmt = serial_mode &&
		format_power[adc_mode_pkg::SIGNED_BIT];
	assign bus.test_en    = serial_mode &&
		pattern_msb[adc_mode_pkg::TEST_EN_BIT];
	// [R24] Pattern assembly
	assign bus.pattern    = {pattern_msb[5:0], pattern_lsb};

	// [R11] Strap sleep
	wire sleep_req = serial_mode ?
		format_power[adc_mode_pkg::SLEEP_BIT] : sdi_s;
	// [R22] Nap bits yield to sleep
	wire [3:0] nap_req = (serial_mode && !sleep_req) ?
		format_power[3:0] : 4'h0;
	// [R19] Momentary sleep
	wire sleep_now = sleep_req || soft_reset;
	// [R09] Strap lane choice
	wire [2:0] lane_next = serial_mode ? output_mode[2:0] :
		(csn_s ? adc_mode_pkg::LANE_1_14 : adc_mode_pkg::LANE_2_16);
	// [R10] Strap drive choice
	wire [2:0] drive_next = serial_mode ?
		output_mode[adc_mode_pkg::DRIVE_LSB +: 3] :
		(sck_s ? adc_mode_pkg::DRIVE_1MA75 : adc_mode_pkg::DRIVE_3MA5);
	// [R12] Strap termination
	wire term_next = serial_mode ?
		output_mode[adc_mode_pkg::TERM_BIT] : sdo_s;
	// [R04] All pairs off
	wire outs_off = serial_mode && output_mode[adc_mode_pkg::OUT_OFF_BIT];
	// [R25] Stabilizer always on in straps
	wire duty_next = serial_mode && format_power[adc_mode_pkg::DUTY_OFF_BIT];

	// Settings leave through flops so pins see no decode glitches
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lane_mode_o               <= adc_mode_pkg::LANE_2_16;
			drive_current_o           <= adc_mode_pkg::DRIVE_3MA5;
			termination_enable_o      <= 1'b0;
			duty_stabilizer_disable_o <= 1'b0;
			data_pair_oe_o            <= 1'b0;
			data_clock_out_oe_o       <= 1'b0;
			frame_marker_oe_o         <= 1'b0;
			sleep_o                   <= 1'b1;
			channel_nap_o             <= 4'h0;
		end else begin
			lane_mode_o               <= lane_next;
			drive_current_o           <= drive_next;
			termination_enable_o      <= term_next;
			duty_stabilizer_disable_o <= duty_next;
			data_pair_oe_o            <= !outs_off;
			data_clock_out_oe_o       <= !outs_off;
			frame_marker_oe_o         <= !outs_off;
			sleep_o                   <= sleep_now;
			channel_nap_o             <= nap_req;
		end
	end

	// ==========================================================
	// Sleep recovery
	logic [SW-1:0] wake_count;   // Cycles since sleep released
	wire wake_done = wake_count == SW'(SLEEP_WAKE_CYCLES);

	// [R05] Two ms wake
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wake_count <= '0;
		end else if (sleep_now) begin
			wake_count <= '0;
		end else if (!wake_done) begin
			wake_count <= wake_count + SW'(1);
		end
	end
	assign converter_ready_o = wake_done;

	// ==========================================================
	// Nap recovery per channel
	logic [3:0] nap_down;   // Channel held down this cycle
	for (genvar ch = 0; ch < 4; ch++) begin : g_nap
		logic [NW-1:0] nap_count;   // Cycles since channel released
		wire nap_done = nap_count == NW'(NAP_WAKE_CYCLES);
		assign nap_down[ch] = nap_req[ch] || sleep_now;

		// [R06] Hundred cycle wake
		always_ff @(posedge clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				nap_count <= '0;
			end else if (nap_down[ch]) begin
				nap_count <= '0;
			end else if (!nap_done) begin
				nap_count <= nap_count + NW'(1);
			end
		end
		// Reference must be up too; nap alone keeps it running
		assign channel_ready_o[ch] = nap_done && wake_done;
	end

	// ==========================================================
	// Checks
	property p_soft_clear;
		@(posedge clk_i) disable iff (sys_rst_i)
		soft_reset |=> format_power == 8'h00 && output_mode == 8'h00 &&
			pattern_msb == 8'h00 && pattern_lsb == 8'h00 && sleep_o;
	endproperty
	a_soft_clear: assert property (p_soft_clear) // [R19]
		else $error("software reset left state behind");

	property p_write_store;
		@(posedge clk_i) disable iff (sys_rst_i)
		wr_format |=> format_power == $past(wr_data);
	endproperty
	a_write_store: assert property (p_write_store) // [R16]
		else $error("format write not stored");

	property p_read_keeps;
		@(posedge clk_i) disable iff (sys_rst_i)
		bus.frame_done && bus.frame_word[15] |=> $stable(format_power) &&
			$stable(output_mode) && $stable(pattern_lsb);
	endproperty
	a_read_keeps: assert property (p_read_keeps) // [R17]
		else $error("read frame changed a register");

	property p_outs_off;
		@(posedge clk_i) disable iff (sys_rst_i)
		serial_mode && output_mode[3] |=> !data_pair_oe_o &&
			!data_clock_out_oe_o && !frame_marker_oe_o;
	endproperty
	a_outs_off: assert property (p_outs_off) // [R04]
		else $error("outputs still driven while disabled");

	property p_nap_wake;
		@(posedge clk_i) disable iff (sys_rst_i)
		$fell(nap_down[0]) ##1 (!nap_down[0])[*8] |-> !channel_ready_o[0];
	endproperty
	a_nap_wake: assert property (p_nap_wake) // [R06]
		else $error("napping channel ready too soon");

	property p_sleep_wake;
		@(posedge clk_i) disable iff (sys_rst_i)
		sleep_now |=> !converter_ready_o ##1 !converter_ready_o;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) // [R05]
		else $error("converter ready during sleep recovery");

	property p_strap_modes;
		@(posedge clk_i) disable iff (sys_rst_i)
		psel_s && csn_s && sdi_s |=> lane_mode_o == 3'h5 && sleep_o &&
			!duty_stabilizer_disable_o;
	endproperty
	a_strap_modes: assert property (p_strap_modes) // [R09]
		else $error("strap decode wrong");

	property p_strap_drive;
		@(posedge clk_i) disable iff (sys_rst_i)
		psel_s && sck_s && sdo_s |=> drive_current_o == 3'h7 &&
			termination_enable_o;
	endproperty
	a_strap_drive: assert property (p_strap_drive) // [R10]
		else $error("strap drive or termination wrong");
endmodule : adc_mode_control_port

// ---- verification/serial_host_model.sv ----
/*
 * Host side of the serial configuration link: one 16-bit word a frame.
 * Assumes a pull-up on the readback line and a 40 MHz bench clock.
 */
`timescale 1ns/10ps
module serial_host_model (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      sdi_o
);
	// ==========================================================
	// Half period of 100 ns; clock stands still between frames
	task automatic half;
		repeat (4) @(negedge clk_i);
	endtask : half

	task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
		cs_n_o = 1'b0;
		half();
		for (int i = 15; i >= 0; i--) begin
			sdi_o = w[i];
			sck_o = 1'b0;
			half();
			sck_o = 1'b1;
			if (i < 8) rd[i] = line_i;
			half();
		end
		sck_o = 1'b0;
		half();
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;  // Toggled: the last data bit flips after select rises
		repeat (8) @(negedge clk_i);
	endtask : xfer

	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
	end
endmodule : serial_host_model

// ---- verification/adc_mode_control_port_tb_top.sv ----
/*
 * Self-checking bench of the mode-control port: serial writes, readback,
 * formatting, power modes and straps. Assumes the design asserts itself.
 */
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module adc_mode_control_port_tb_top;
	logic             clk_i = 0, sys_rst_i = 1, psel = 0;
	logic [3:0]       strap = 4'h0;  // Select, clock, data in, data out
	logic [3:0][13:0] smp = '0;
	logic [13:0]      pat;
	logic             rnd = 0, sgn = 0, tst = 0;
	logic [7:0]       rdv;
	logic [67:0]      notes[$];  // Selector and expected value
	logic [67:0]      nt;
	event             tick;
	int               n_errors = 0, compares = 0;
	wire              h_cs, h_sck, h_sdi, oe, so;
	wire [3:0][13:0]  sb;
	wire [3:0]        nap, chr;
	wire [2:0]        lane, drv;
	wire              dp, data_clock_out, fm, slp, rdy, trm, dso;
	// Pull-up on the open-drain line; strap mode drives it instead
	wire line = psel ? strap[0] : (oe ? so : 1'b1);

	// ==========================================================
	// Clock, design and host
	initial forever #12.5 clk_i = ~clk_i;
	adc_mode_control_port #(.SLEEP_WAKE_CYCLES(50), .NAP_WAKE_CYCLES(10))
	adc_mode_control_port_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.programming_select_i(psel), .serial_out_i(line),
		.chip_select_n_i(psel ? strap[3] : h_cs),
		.serial_clock_i(psel ? strap[2] : h_sck),
		.serial_data_i(psel ? strap[1] : h_sdi), .sample_i(smp),
		.serial_out_o(so), .serial_out_oe_o(oe), .sample_bits_o(sb),
		.data_pair_oe_o(dp), .data_clock_out_oe_o(data_clock_out),
		.frame_marker_oe_o(fm), .sleep_o(slp), .channel_nap_o(nap),
		.converter_ready_o(rdy), .channel_ready_o(chr), .lane_mode_o(lane),
		.drive_current_o(drv), .termination_enable_o(trm),
		.duty_stabilizer_disable_o(dso));
	serial_host_model serial_host_model_inst (.clk_i(clk_i), .line_i(line),
		.cs_n_o(h_cs), .sck_o(h_sck), .sdi_o(h_sdi));

	// ==========================================================
	// Helpers: observed group, expected format, notes
	function automatic logic [63:0] obs(input logic [3:0] s);
		case (s)
			4'h0: obs = {8'h00, sb};
			4'h1: obs = {61'h0, dp, data_clock_out, fm};
			4'h2: obs = {54'h0, rdy, chr, slp, nap};
			4'h3: obs = {55'h0, lane, drv, trm, dso, slp};
			default: obs = {56'h0, rdv};
		endcase
	endfunction : obs
	function automatic logic [55:0] fmt(input logic [55:0] s);
		logic [13:0] v;
		for (int c = 0; c < 4; c++) begin
			v = s[c*14+:14];
			if (sgn) v[13] = ~v[13];  // Coding first, then randomizer
			if (rnd) v[13:1] = v[13:1] ^ {13{v[0]}};
			if (tst) v = pat;  // Pattern wins over both
			fmt[c*14+:14] = v;
		end
	endfunction : fmt
	task automatic note(input logic [3:0] s, input logic [63:0] e);
		notes.push_back({s, e});
		->tick;
	endtask : note
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		serial_host_model_inst.xfer({1'b0, a, d}, rdv);
	endtask : wr
	task automatic rd(input logic [6:0] a);
		serial_host_model_inst.xfer({1'b1, a, 8'h00}, rdv);
	endtask : rd
	task automatic samples;
		for (int k = 0; k < 4; k++) begin
			smp = 56'({$urandom(), $urandom()});
			@(negedge clk_i);
			note(4'h0, {8'h00, fmt(smp)});
			@(negedge clk_i);
		end
	endtask : samples
	task automatic wait_ready;
		int n = 0;
		while (rdy !== 1'b1 && n < 500) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 500) begin
			n_errors++;
			tally_and_finish();
		end
	endtask : wait_ready
	task tally_and_finish;
		$display("counts: %0d compares, %0d mismatches", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// Monitor: oldest note against the outputs
	initial forever begin
		@tick;
		nt = notes.pop_front();
		`CHK(obs(nt[67:64]), nt[63:0])
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h0ca0));
		repeat (2) @(posedge clk_i);
		@(negedge clk_i) sys_rst_i = 0;
		repeat (4) @(negedge clk_i);
		wr(7'h00, 8'h80);  // reset first
		wr(7'h01, 8'h60);
		{rnd, sgn} = 2'b11;
		rd(7'h01);
		note(4'h4, 64'h60);
		samples();
		rd(7'h00);
		note(4'h4, 64'h00);
		$display("done: format and readback");
		pat = 14'($urandom());
		wr(7'h03, {2'b10, pat[13:8]});
		wr(7'h04, pat[7:0]);
		tst = 1;
		samples();
		wr(7'h02, 8'h08);
		note(4'h1, 64'h0);
		wr(7'h02, 8'h00);
		note(4'h1, 64'h7);
		$display("done: pattern and disable");
		wr(7'h01, 8'h05);
		note(4'h2, 64'h345);
		wr(7'h01, 8'h10);
		note(4'h2, 64'h10);
		wr(7'h01, 8'h00);
		wait_ready();
		note(4'h2, 64'h3e0);
		repeat (2000) @(negedge clk_i);
		wr(7'h00, 8'h80);
		{rnd, sgn, tst} = 3'b000;
		rd(7'h03);
		note(4'h4, 64'h00);
		samples();
		$display("done: power and soft reset");
		psel = 1;
		for (int k = 0; k < 2; k++) begin
			strap = k ? 4'hf : 4'h0;
			repeat (8) @(negedge clk_i);
			note(4'h3, k ? 64'h17d : 64'h0);
		end
		$display("done: straps");
		@(negedge clk_i);
		tally_and_finish();
	end
endmodule : adc_mode_control_port_tb_top
